// ==== shared/parport_pkg.sv ====
// constants shared by the parallel port register block.
// assumes a 100 MHz system clock and byte-wide host i/o cycles.
package parport_pkg;
   // register offsets from the configured base address
   localparam logic [2:0] OFF_DATA = 3'h0;
   localparam logic [2:0] OFF_STATUS = 3'h1;
   localparam logic [2:0] OFF_CONTROL = 3'h2;
   localparam logic [2:0] OFF_EPP_ADDR = 3'h3;
   localparam logic [2:0] OFF_EPP_DATA_0 = 3'h4;
   // status field positions
   localparam int ST_TRANSFER_TIMEOUT_FLAG = 0;
   localparam int ST_ERROR_N = 3;
   localparam int ST_ONLINE = 4;
   localparam int ST_PAPER_END = 5;
   localparam int ST_ACK_N = 6;
   localparam int ST_READY = 7;
   // control field positions
   localparam int CT_STROBE = 0;
   localparam int CT_AUTO_FEED = 1;
   localparam int CT_INIT = 2;
   localparam int CT_SELECT_IN = 3;
   localparam int CT_IRQ_EN = 4;
   localparam int CT_DIR = 5;
   // reset values
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [5:0] CONTROL_RESET = 6'h00;
   // fixed bits read back
   localparam logic [1:0] STATUS_ONES = 2'b11;
   localparam logic [1:0] CONTROL_ONES = 2'b11;
   // enhanced transfer watchdog
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIMEOUT_MS = 10;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   // operating mode as set by configuration
   typedef enum logic [1:0] {
      MODE_SPP = 2'b00,
      MODE_EPP = 2'b01,
      MODE_ECP = 2'b10
   } port_mode_t;
endpackage : parport_pkg

// ==== src/parport_spp_epp.sv ====
// standard and enhanced parallel port: data, status, control and enhanced
// address/data ports, pin control and the enhanced handshake watchdog.
// assumes host i/o cycles arrive as held read/write levels with a byte address,
// and that all connector inputs are already synchronous to clk_sys.
//
// How it works
// - data port is an eight-bit readable and writable byte to the lines.
// - control bit 5 low drives lines from data port, high takes them in.
// - status port ignores writes except a one to bit 0.
// - status value is captured at the moment the host read is taken.
// - status bit 7 is the inverted busy line.
// - status bit 6 is the acknowledge line level.
// - bit 5 paper end, bit 4 online, bit 3 error line low means error.
// - status bits 1 and 2 always read one.
// - status bit 0 sets when an enhanced transfer exceeds 10 ms.
// - timeout flag clears on reset or host writing one to bit 0.
// - timeout flag reads one whenever the port is not in enhanced mode.
// - control port readable and writable, bits 6 and 7 read one.
// - acknowledge rising edge raises interrupt only while control bit 4 is set.
// - select-in pin is inverted control bit 3.
// - initialize pin follows control bit 2, zero initializes.
// - auto-feed pin is inverted control bit 1.
// - strobe pin is inverted control bit 0.
// - offsets 0-2 always decode, 3 to 7 only in enhanced mode.
// - enhanced mode reuses strobe, auto-feed, select-in and busy pins.
// - base address comes from two configuration bytes.
// - enhanced port access drives or samples lines and runs a cycle.
// - enhanced transfer not finished within 10 ms is aborted with flag set.
// - write/strobe asserted, wait high drops strobe, wait low drops write.
`timescale 1ns/1ps
`default_nettype none
module parport_spp_epp #(
   parameter int TIMEOUT_CYCLES = parport_pkg::TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // configuration
   input wire logic [7:0] base_addr_hi,
   input wire logic [7:0] base_addr_lo,
   input wire parport_pkg::port_mode_t port_mode,
   // host i/o cycles
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic host_write_cycle,
   input wire logic host_read_cycle,
   output logic [7:0] io_rdata,
   output logic io_done,
   output logic peripheral_interrupt,
   // connector data lines
   input wire logic [7:0] pd_in,
   output logic [7:0] pd_out,
   output logic pd_oe_n,
   // connector control outputs
   output logic strobe_n,
   output logic auto_feed_n,
   output logic init_n,
   output logic select_in_n,
   // connector status inputs
   input wire logic busy,
   input wire logic ack_n,
   input wire logic paper_end_status,
   input wire logic printer_online_status,
   input wire logic error_n
);
   localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_HI,
      ST_WAIT_LO,
      ST_ANSWER
   } state_t;

   state_t state;
   logic [7:0] data_reg;
   logic [5:0] ctl;
   logic transfer_timeout_flag;
   logic [CW-1:0] tmo_cnt;
   logic epp_is_write;
   logic epp_is_addr;
   logic [2:0] cur_off;
   logic rd_q;
   logic wr_q;
   logic ack_q;
   logic [15:0] base;
   logic [15:0] rel;
   logic hit;
   logic rd_start;
   logic wr_start;
   logic start;
   logic epp_mode;
   logic epp_off;
   logic epp_busy;
   logic tmo_hit;
   logic port_direction_sel;
   logic ack_interrupt_enable;
   logic wait_n;
   logic [7:0] status_now;
   logic [7:0] control_now;

   // decode against the configured base
   assign base = {base_addr_hi, base_addr_lo};
   assign rel = io_addr - base;
   assign epp_mode = (port_mode == parport_pkg::MODE_EPP);
   assign epp_off = (rel[2:0] >= parport_pkg::OFF_EPP_ADDR);
   assign hit = (rel[15:3] == 13'h0000) && (!epp_off || epp_mode);
   // only the leading edge of a cycle starts an access
   assign rd_start = host_read_cycle && !rd_q && hit;
   assign wr_start = host_write_cycle && !wr_q && hit && !host_read_cycle;
   assign start = (rd_start || wr_start) && (state == ST_IDLE);
   assign epp_busy = (state == ST_WAIT_HI) || (state == ST_WAIT_LO);
   assign tmo_hit = epp_busy && (tmo_cnt == CW'(TIMEOUT_CYCLES - 1));
   assign port_direction_sel = ctl[parport_pkg::CT_DIR];
   assign ack_interrupt_enable = ctl[parport_pkg::CT_IRQ_EN];
   assign wait_n = busy;
   assign io_done = (state == ST_ANSWER);

   always_comb begin
      status_now = {!busy, ack_n, paper_end_status, printer_online_status,
                    error_n, parport_pkg::STATUS_ONES,
                    transfer_timeout_flag || !epp_mode};
      control_now = {parport_pkg::CONTROL_ONES, ctl};
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         ack_q <= 1'b1;
      end else begin
         rd_q <= host_read_cycle;
         wr_q <= host_write_cycle;
         ack_q <= ack_n;
      end
   end

   // access sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cur_off <= parport_pkg::OFF_DATA;
         epp_is_write <= 1'b0;
         epp_is_addr <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  cur_off <= rel[2:0];
                  epp_is_write <= wr_start;
                  epp_is_addr <= (rel[2:0] == parport_pkg::OFF_EPP_ADDR);
                  state <= epp_off ? ST_WAIT_HI : ST_ANSWER;
               end
            end
            ST_WAIT_HI: begin
               if (tmo_hit) begin
                  state <= ST_ANSWER;
               end else if (wait_n) begin
                  state <= ST_WAIT_LO;
               end
            end
            ST_WAIT_LO: begin
               if (tmo_hit || !wait_n) begin
                  state <= ST_ANSWER;
               end
            end
            ST_ANSWER: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // watchdog counts from the start of the enhanced cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tmo_cnt <= '0;
      end else if (epp_busy && !tmo_hit) begin
         tmo_cnt <= tmo_cnt + CW'(1);
      end else begin
         tmo_cnt <= '0;
      end
   end

   // timeout flag: a new timeout wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         transfer_timeout_flag <= 1'b0;
      end else if (tmo_hit) begin
         transfer_timeout_flag <= 1'b1;
      end else if (start && wr_start && rel[2:0] == parport_pkg::OFF_STATUS
                   && io_wdata[parport_pkg::ST_TRANSFER_TIMEOUT_FLAG]) begin
         transfer_timeout_flag <= 1'b0;
      end
   end

   // data and control registers; status offset has no write effect
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         data_reg <= parport_pkg::DATA_RESET;
         ctl <= parport_pkg::CONTROL_RESET;
      end else if (start && wr_start) begin
         if (rel[2:0] == parport_pkg::OFF_DATA || epp_off) begin
            data_reg <= io_wdata;
         end else if (rel[2:0] == parport_pkg::OFF_CONTROL) begin
            ctl <= io_wdata[5:0];
         end
      end
   end

   // read data: snapshot at the taken read, or lines at wait release
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         io_rdata <= 8'h00;
      end else if (start && rd_start) begin
         unique case (rel[2:0])
            parport_pkg::OFF_DATA: io_rdata <= port_direction_sel ? pd_in : data_reg;
            parport_pkg::OFF_STATUS: io_rdata <= status_now;
            parport_pkg::OFF_CONTROL: io_rdata <= control_now;
            default: io_rdata <= 8'h00;
         endcase
      end else if (!epp_is_write && (state == ST_WAIT_HI) && (wait_n || tmo_hit)) begin
         io_rdata <= pd_in;
      end
   end

   // acknowledge rising edge, gated by the enable bit
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         peripheral_interrupt <= 1'b0;
      end else begin
         peripheral_interrupt <= ack_interrupt_enable && ack_n && !ack_q;
      end
   end

   // pins: hardware owns the strobes only while an enhanced cycle runs,
   // so stale control bits cannot glitch them mid-handshake
   always_comb begin
      strobe_n = !ctl[parport_pkg::CT_STROBE];
      auto_feed_n = !ctl[parport_pkg::CT_AUTO_FEED];
      select_in_n = !ctl[parport_pkg::CT_SELECT_IN];
      init_n = ctl[parport_pkg::CT_INIT];
      pd_oe_n = port_direction_sel;
      if (epp_busy) begin
         strobe_n = !epp_is_write;
         auto_feed_n = !((state == ST_WAIT_HI) && !epp_is_addr);
         select_in_n = !((state == ST_WAIT_HI) && epp_is_addr);
         pd_oe_n = !epp_is_write;
      end
   end
   assign pd_out = data_reg;

   sequence epp_wr_phase_s;
      (state == ST_WAIT_HI) && epp_is_write && wait_n && !tmo_hit;
   endsequence

   sequence epp_released_s;
      auto_feed_n && select_in_n && !strobe_n;
   endsequence

   epp_write_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      epp_wr_phase_s |=> epp_released_s)
      else $error("strobe not released with write held after wait high");

   status_ones_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      io_done && !epp_busy && cur_off == parport_pkg::OFF_STATUS && !epp_is_write
      |-> io_rdata[2:1] == 2'b11)
      else $error("status reserved bits not one");

   ctrl_ones_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      io_done && cur_off == parport_pkg::OFF_CONTROL && !epp_is_write |-> io_rdata[7:6] == 2'b11)
      else $error("control reserved bits not one");

   transfer_timeout_flag_nonepp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start && rd_start && rel[2:0] == parport_pkg::OFF_STATUS && !epp_mode |=> io_rdata[0])
      else $error("timeout bit not one outside enhanced mode");

   dir_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == ST_IDLE |-> pd_oe_n == ctl[5])
      else $error("data driver does not follow direction bit");

   select_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !epp_busy |-> select_in_n == !ctl[3] && init_n == ctl[2])
      else $error("select or init pin wrong");

   irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      peripheral_interrupt |-> $past(ctl[4]) && $past(ack_n) && !$past(ack_q))
      else $error("interrupt without enabled acknowledge edge");

   timeout_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tmo_hit |=> transfer_timeout_flag && state == ST_ANSWER ##1 state == ST_IDLE)
      else $error("timeout did not abort and flag");

   flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start && wr_start && rel[2:0] == parport_pkg::OFF_STATUS && io_wdata[0]
      |=> !transfer_timeout_flag)
      else $error("timeout flag not cleared by write of one");

   sequence epp_wait_back_s;
      (state == ST_WAIT_LO) && !wait_n && !tmo_hit;
   endsequence

   sequence epp_closed_s;
      io_done && strobe_n == !ctl[0] && auto_feed_n == !ctl[1] && select_in_n == !ctl[3] ##1 state == ST_IDLE;
   endsequence

   epp_finish_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      epp_wait_back_s |=> epp_closed_s)
      else $error("enhanced cycle did not close after wait low");

   status_readonly_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start && wr_start && rel[2:0] == parport_pkg::OFF_STATUS |=> $stable(data_reg) && $stable(ctl))
      else $error("status write changed a register");

   status_snap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start && rd_start && rel[2:0] == parport_pkg::OFF_STATUS |=> io_rdata[7:3] ==
      {!$past(busy), $past(ack_n), $past(paper_end_status), $past(printer_online_status), $past(error_n)})
      else $error("status snapshot does not match the pins at the read");

   data_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start && rd_start && rel[2:0] == parport_pkg::OFF_DATA && !port_direction_sel |=> io_rdata == $past(data_reg))
      else $error("data port read does not return the written byte");

   strobe_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !epp_busy |-> strobe_n == !ctl[0] && auto_feed_n == !ctl[1])
      else $error("strobe or auto feed pin wrong");

   epp_mode_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !epp_mode && state == ST_IDLE |=> !epp_busy)
      else $error("enhanced cycle started outside enhanced mode");

   epp_read_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      epp_busy && !epp_is_write |-> strobe_n && pd_oe_n)
      else $error("enhanced read drives write strobe or data lines");

   epp_strobe_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == ST_WAIT_HI |-> select_in_n == !epp_is_addr && auto_feed_n == epp_is_addr)
      else $error("wrong enhanced strobe asserted");

   wdog_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      epp_busy && !tmo_hit |=> tmo_cnt == $past(tmo_cnt) + CW'(1))
      else $error("enhanced watchdog did not advance");

   epp_read_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !epp_is_write && state == ST_WAIT_HI && wait_n |=> io_rdata == $past(pd_in))
      else $error("enhanced read did not latch the lines");

   flag_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      transfer_timeout_flag && !(start && wr_start && rel[2:0] == parport_pkg::OFF_STATUS && io_wdata[0])
      |=> transfer_timeout_flag)
      else $error("timeout flag lost without a clear");

   irq_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      peripheral_interrupt |=> !peripheral_interrupt)
      else $error("interrupt longer than one cycle");
endmodule : parport_spp_epp
`default_nettype wire

// ==== tb/printer_model.sv ====
// printer side of the connector: wait handshake and reverse data lines.
// assumes pins are sampled on clk_sys and the bench sets the status levels.
`timescale 1ns/1ps
`default_nettype none
module printer_model (
   // clock
   input wire logic clk_sys,
   // pins from the port
   input wire logic [7:0] pd_out,
   input wire logic pd_oe_n,
   input wire logic auto_feed_n,
   input wire logic select_in_n,
   // bench controls
   input wire logic [7:0] rd_byte,
   input wire logic drive,
   input wire logic hang,
   input wire logic [3:0] delay,
   input wire logic busy_lvl,
   // pins to the port
   output logic [7:0] pd_in,
   output logic busy
);
   logic wait_hi = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic stb;
   assign stb = !auto_feed_n || !select_in_n;
   // released lines show the inverse so a stale byte never passes as valid
   assign pd_in = !pd_oe_n ? pd_out : (drive || stb) ? rd_byte : ~rd_byte;
   assign busy = busy_lvl | wait_hi;
   // wait follows the strobe after delay cycles; hang never answers
   always @(posedge clk_sys) begin
      if (stb == wait_hi || hang) begin
         cnt <= 4'h0;
      end else if (cnt >= delay) begin
         wait_hi <= stb;
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule : printer_model
`default_nettype wire

// ==== tb/tb.sv ====
// bench for the parallel port: host cycles, pin levels and enhanced handshake.
// assumes the printer model answers the enhanced strobes.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [15:0] BASE = 16'h0378;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   parport_pkg::port_mode_t port_mode = parport_pkg::MODE_SPP;
   logic [15:0] io_addr = BASE;
   logic [7:0] io_wdata = 8'h00, rd_byte = 8'h00, pd_in, pd_out, io_rdata, q, lat;
   logic host_write_cycle = 1'b0, host_read_cycle = 1'b0, io_done, peripheral_interrupt, pd_oe_n;
   logic strobe_n, auto_feed_n, init_n, select_in_n, busy, ack_n = 1'b1, pe = 1'b0, sel = 1'b0;
   logic err_n = 1'b1, drive = 1'b0, hang = 1'b0, busy_lvl = 1'b0, sw, sd, sa;
   logic [3:0] dly = 4'h1;
   int mismatches = 0, n_tests = 0, irqs = 0, waited = 0, k;
   always #5 clk_sys = ~clk_sys;
   parport_spp_epp #(.TIMEOUT_CYCLES(50)) u_parport_spp_epp (.clk_sys(clk_sys), .rst_n(rst_n),
      .base_addr_hi(BASE[15:8]), .base_addr_lo(BASE[7:0]), .port_mode(port_mode), .io_addr(io_addr),
      .io_wdata(io_wdata), .host_write_cycle(host_write_cycle), .host_read_cycle(host_read_cycle),
      .io_rdata(io_rdata), .io_done(io_done), .peripheral_interrupt(peripheral_interrupt),
      .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .strobe_n(strobe_n), .auto_feed_n(auto_feed_n),
      .init_n(init_n), .select_in_n(select_in_n), .busy(busy), .ack_n(ack_n), .paper_end_status(pe),
      .printer_online_status(sel), .error_n(err_n));
   printer_model u_printer_model (.clk_sys(clk_sys), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
      .auto_feed_n(auto_feed_n), .select_in_n(select_in_n), .rd_byte(rd_byte), .drive(drive),
      .hang(hang), .delay(dly), .busy_lvl(busy_lvl), .pd_in(pd_in), .busy(busy));
   // strobes and line byte seen during the current cycle
   always @(posedge clk_sys) begin
      if (!strobe_n) sw <= 1'b1;
      if (!auto_feed_n) begin
         sd <= 1'b1;
         lat <= pd_out;
      end
      if (!select_in_n) begin
         sa <= 1'b1;
         lat <= pd_out;
      end
      if (peripheral_interrupt === 1'b1) irqs <= irqs + 1;
   end
   task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // one host cycle held until io_done, then released for a cycle
   task acc(input logic w, input logic [2:0] off, input logic [7:0] d, input logic ex);
      logic got;
      int n;
      got = 1'b0;
      {sw, sd, sa} = 3'b000;
      io_addr = BASE + 16'(off);
      io_wdata = d;
      host_write_cycle = w;
      host_read_cycle = !w;
      for (n = 0; n < 200 && !got; n++) begin
         @(posedge clk_sys);
         #1 got = io_done === 1'b1;
      end
      waited = n;
      q = io_rdata;
      check("io_done", {7'h00, got}, {7'h00, ex});
      @(posedge clk_sys);
      #1 {host_write_cycle, host_read_cycle} = 2'b00;
      @(posedge clk_sys);
      #1;
   endtask : acc
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      check("pins", {4'h0, strobe_n, auto_feed_n, init_n, select_in_n}, 8'h0D);
      acc(1'b0, 3'd2, 8'h00, 1'b1);
      check("control", q, 8'hC0);
      for (k = 0; k < 4; k++) begin
         acc(1'b1, 3'd2, 8'(1 << k), 1'b1);
         check("pins", {4'h0, strobe_n, auto_feed_n, init_n, select_in_n},
               {4'h0, k != 0, k != 1, k == 2, k != 3});
         acc(1'b0, 3'd2, 8'h00, 1'b1);
         check("control", q, 8'hC0 | 8'(1 << k));
      end
      acc(1'b1, 3'd0, 8'hA5, 1'b1);
      acc(1'b0, 3'd0, 8'h00, 1'b1);
      check("data", q, 8'hA5);
      check("lines", pd_out, 8'hA5);
      check("oe_n", {7'h00, pd_oe_n}, 8'h00);
      acc(1'b1, 3'd2, 8'h20, 1'b1);
      check("oe_n", {7'h00, pd_oe_n}, 8'h01);
      rd_byte = 8'h5A;
      drive = 1'b1;
      acc(1'b0, 3'd0, 8'h00, 1'b1);
      drive = 1'b0;
      check("data", q, 8'h5A);
      for (k = 0; k < 2; k++) begin
         {busy_lvl, ack_n, pe, sel, err_n} = (k == 1) ? 5'b01010 : 5'b10101;
         acc(1'b1, 3'd1, 8'hFE, 1'b1);
         acc(1'b0, 3'd1, 8'h00, 1'b1);
         check("status", q, (k == 1) ? 8'hD7 : 8'h2F);
      end
      acc(1'b0, 3'd2, 8'h00, 1'b1);
      check("control", q, 8'hE0);
      check("irq", 8'(irqs), 8'h00);
      acc(1'b1, 3'd2, 8'h10, 1'b1);
      ack_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 ack_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 check("irq", 8'(irqs), 8'h01);
      port_mode = parport_pkg::MODE_EPP;
      acc(1'b1, 3'd2, 8'h00, 1'b1);
      acc(1'b0, 3'd1, 8'h00, 1'b1);
      check("transfer_timeout_flag", {7'h00, q[0]}, 8'h00);
      for (k = 3; k < 8; k++) begin
         dly = 4'(k - 3);
         acc(1'b1, 3'(k), 8'(k * 17), 1'b1);
         check("strobes", {5'h00, sw, sa, sd}, {5'h00, 1'b1, k == 3, k != 3});
         check("lines", lat, 8'(k * 17));
      end
      rd_byte = 8'hC3;
      acc(1'b0, 3'd3, 8'h00, 1'b1);
      check("strobes", {5'h00, sw, sa, sd}, 8'h02);
      check("epp read", q, 8'hC3);
      rd_byte = 8'h3C;
      acc(1'b0, 3'd7, 8'h00, 1'b1);
      check("strobes", {5'h00, sw, sa, sd}, 8'h01);
      check("epp read", q, 8'h3C);
      hang = 1'b1;
      acc(1'b1, 3'd4, 8'h99, 1'b1);
      hang = 1'b0;
      check("abort wait", {7'h00, waited >= 50}, 8'h01);
      acc(1'b0, 3'd1, 8'h00, 1'b1);
      check("transfer_timeout_flag", {7'h00, q[0]}, 8'h01);
      acc(1'b1, 3'd1, 8'h01, 1'b1);
      acc(1'b0, 3'd1, 8'h00, 1'b1);
      check("transfer_timeout_flag", {7'h00, q[0]}, 8'h00);
      hang = 1'b1;
      acc(1'b1, 3'd4, 8'h99, 1'b1);
      hang = 1'b0;
      acc(1'b0, 3'd1, 8'h00, 1'b1);
      check("transfer_timeout_flag", {7'h00, q[0]}, 8'h01);
      rst_n = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      acc(1'b0, 3'd1, 8'h00, 1'b1);
      check("transfer_timeout_flag", {7'h00, q[0]}, 8'h00);
      port_mode = parport_pkg::MODE_ECP;
      acc(1'b0, 3'd1, 8'h00, 1'b1);
      check("transfer_timeout_flag", {7'h00, q[0]}, 8'h01);
      port_mode = parport_pkg::MODE_SPP;
      acc(1'b1, 3'd4, 8'h11, 1'b0);
      conclude();
   end
endmodule : tb
`default_nettype wire
